/* hw/bcs_pkg.sv */
// Package: register map, field layout, reset values and timing for the bridge config block
package bcs_pkg;
	// ====================================================================
	// Register indices as printed; byte address is four times the index
	localparam logic [7:0] IDX_STRAP = 8'h13;
	localparam logic [7:0] IDX_SELFTEST = 8'h14;
	localparam logic [7:0] IDX_LEVEL = 8'h15;
	localparam logic [7:0] IDX_WDOG = 8'h16;
	localparam logic [7:0] IDX_BUSSET = 8'h17;
	localparam logic [7:0] IDX_SCLHIGH = 8'h18;
	localparam int ADDR_W = 8;
	// ====================================================================
	// Reset values
	localparam logic [7:0] RST_STRAP = 8'h88;
	localparam logic [7:0] RST_SELFTEST = 8'h00;
	localparam logic [7:0] RST_LEVEL = 8'h01;
	localparam logic [7:0] RST_WDOG = 8'hFE;
	localparam logic [7:0] RST_BUSSET = 8'h1E;
	localparam logic [7:0] RST_SCLHIGH = 8'h7F;
	// ====================================================================
	// Field positions
	localparam int STRAP_B_DONE = 7;
	localparam int STRAP_A_DONE = 3;
	localparam int SELFTEST_EN = 0;
	localparam int WDOG_DIS = 0;
	localparam int BUSSET_PASS = 7;
	localparam logic [7:0] SELFTEST_MASK = 8'h07;
	localparam logic [7:0] LEVEL_SET = 8'hB5;
	localparam logic [7:0] LEVEL_CLR = 8'hB6;
	localparam logic [8:0] SCL_EXTRA = 9'h005;
	// ====================================================================
	// Clock source codes driven to the clock mux
	typedef enum logic [2:0] {
		BCS_SRC_NONE, BCS_SRC_OSC50, BCS_SRC_OSC100, BCS_SRC_OSC25, BCS_SRC_PIXEL, BCS_SRC_OSC33
	} bcs_src_t;
	// ====================================================================
	// Timing
	localparam longint CLK_HZ = 40000000;
	localparam longint WDOG_UNIT_MS = 2;
	localparam int WDOG_UNIT_CYC = int'(CLK_HZ * WDOG_UNIT_MS / 1000);
	localparam longint STRAP_SETTLE_NS = 1000;
	localparam int STRAP_SETTLE_CYC = int'((STRAP_SETTLE_NS * CLK_HZ + 999999999) / 1000000000);
endpackage : bcs_pkg

/* hw/bcs_regs.sv */
// Configuration and status register bank with APB slave, straps, watchdog and forwarding
//
// Our own choice: the APB register port.
module bcs_regs #(
	parameter int WDOG_UNIT = bcs_pkg::WDOG_UNIT_CYC,
	parameter int SETTLE = bcs_pkg::STRAP_SETTLE_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [bcs_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [2:0] strap_pin_a,
	input wire logic [2:0] strap_pin_b,
	input wire logic strap_scl,
	input wire logic digital_reset,
	input wire logic tmds_clk_present,
	input wire logic osc_use,
	input wire logic bcc_busy,
	input wire logic second_port_select,
	input wire logic acc_valid,
	input wire logic [6:0] acc_id,
	input wire logic [6:0] own_id,
	input wire logic [6:0] remote_deser_id,
	input wire logic [6:0] remote_target_id,
	output logic signalling_level_ctrl,
	output bcs_pkg::bcs_src_t clk_src,
	output logic self_test_en,
	output logic bcc_abort,
	output logic fwd_port0,
	output logic fwd_port1,
	output logic [2:0] sda_hold_steps,
	output logic [3:0] glitch_steps,
	output logic [8:0] scl_high_periods
);
	// ====================================================================
	// Address decode
	function automatic logic hit(input logic [bcs_pkg::ADDR_W-1:0] a, input logic [7:0] idx);
		hit = (a == {idx[5:0], 2'b00});
	endfunction : hit

	// ====================================================================
	// APB slave: one wait state, so pready is a flop like every other output
	logic [7:0] wd;
	logic access;
	logic wr;
	logic next_pready;
	logic next_pslverr;
	logic [31:0] next_prdata;
	logic mapped;
	logic [7:0] rd;
	logic [7:0] strap_reg;
	logic [7:0] selftest;
	logic level;
	logic [7:0] wdog;
	logic [7:0] busset;
	logic pass0;
	logic pass1;
	logic [7:0] sclhigh;

	assign wd = pwdata[7:0];
	assign access = psel && penable;
	assign wr = access && pwrite && pready;

	always_comb begin
		mapped = 1'b1;
		rd = 8'h00;
		if (hit(paddr, bcs_pkg::IDX_STRAP)) begin
			rd = strap_reg;
		end else if (hit(paddr, bcs_pkg::IDX_SELFTEST)) begin
			rd = selftest & bcs_pkg::SELFTEST_MASK;
		end else if (hit(paddr, bcs_pkg::IDX_LEVEL)) begin
			rd = {7'h00, level};
		end else if (hit(paddr, bcs_pkg::IDX_WDOG)) begin
			rd = wdog;
		end else if (hit(paddr, bcs_pkg::IDX_BUSSET)) begin
			rd = busset;
			rd[bcs_pkg::BUSSET_PASS] = second_port_select ? pass1 : pass0;
		end else if (hit(paddr, bcs_pkg::IDX_SCLHIGH)) begin
			rd = sclhigh;
		end else begin
			mapped = 1'b0;
		end
		next_pready = access && !pready;
		next_pslverr = access && !pready && !mapped;
		next_prdata = (access && !pready && !pwrite) ? {24'h000000, rd} : 32'h00000000;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= next_pready;
			pslverr <= next_pslverr;
			prdata <= next_prdata;
		end
	end

	// ====================================================================
	// Strap capture: three-stage sync, then a settle count before latching
	logic [6:0] s1;
	logic [6:0] s2;
	logic [6:0] s3;
	logic [15:0] settle;
	logic latched;
	logic [15:0] next_settle;
	logic next_latched;
	logic [7:0] next_strap;
	logic strap_load;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1 <= 7'h00;
			s2 <= 7'h00;
			s3 <= 7'h00;
		end else begin
			s1 <= {strap_scl, strap_pin_b, strap_pin_a};
			s2 <= s1;
			s3 <= s2;
		end
	end

	always_comb begin
		next_settle = settle;
		next_latched = latched;
		next_strap = strap_reg;
		strap_load = 1'b0;
		if (!latched) begin
			if (s2 != s3) begin
				next_settle = 16'h0000;
			end else if (settle == 16'(SETTLE - 1)) begin
				strap_load = 1'b1;
				next_latched = 1'b1;
				next_strap = {1'b1, s3[5:3], 1'b1, 1'b0, s3[1:0]};
			end else begin
				next_settle = settle + 16'h0001;
			end
		end
	end

	// Done bits stay low until the latch; reads before then show no valid mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settle <= 16'h0000;
			latched <= 1'b0;
			strap_reg <= bcs_pkg::RST_STRAP & 8'h77;
		end else begin
			settle <= next_settle;
			latched <= next_latched;
			strap_reg <= next_strap;
		end
	end

	// ====================================================================
	// Writable registers
	logic [7:0] next_selftest;
	logic next_level;
	logic [7:0] next_wdog;
	logic [7:0] next_busset;
	logic next_pass0;
	logic next_pass1;
	logic [7:0] next_sclhigh;

	always_comb begin
		next_selftest = selftest;
		next_level = level;
		next_wdog = wdog;
		next_busset = busset;
		next_pass0 = pass0;
		next_pass1 = pass1;
		next_sclhigh = sclhigh;
		if (strap_load) begin
			next_level = !s3[6];
		end
		if (wr) begin
			if (hit(paddr, bcs_pkg::IDX_SELFTEST)) begin
				next_selftest = wd & bcs_pkg::SELFTEST_MASK;
			end
			if (hit(paddr, bcs_pkg::IDX_LEVEL)) begin
				if (wd == bcs_pkg::LEVEL_SET) begin
					next_level = 1'b1;
				end else if (wd == bcs_pkg::LEVEL_CLR) begin
					next_level = 1'b0;
				end
			end
			if (hit(paddr, bcs_pkg::IDX_WDOG)) begin
				next_wdog = wd;
			end
			if (hit(paddr, bcs_pkg::IDX_BUSSET)) begin
				next_busset = wd;
				if (second_port_select) begin
					next_pass1 = wd[bcs_pkg::BUSSET_PASS];
				end else begin
					next_pass0 = wd[bcs_pkg::BUSSET_PASS];
				end
			end
			if (hit(paddr, bcs_pkg::IDX_SCLHIGH)) begin
				next_sclhigh = wd;
			end
		end
		if (digital_reset) begin
			next_level = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			selftest <= bcs_pkg::RST_SELFTEST;
			level <= bcs_pkg::RST_LEVEL[0];
			wdog <= bcs_pkg::RST_WDOG;
			busset <= bcs_pkg::RST_BUSSET;
			pass0 <= bcs_pkg::RST_BUSSET[bcs_pkg::BUSSET_PASS];
			pass1 <= bcs_pkg::RST_BUSSET[bcs_pkg::BUSSET_PASS];
			sclhigh <= bcs_pkg::RST_SCLHIGH;
		end else begin
			selftest <= next_selftest;
			level <= next_level;
			wdog <= next_wdog;
			busset <= next_busset;
			pass0 <= next_pass0;
			pass1 <= next_pass1;
			sclhigh <= next_sclhigh;
		end
	end

	// ====================================================================
	// Watchdog: prescaler gives a unit tick, unit counter compares to field
	logic [31:0] pre;
	logic [6:0] units;
	logic fired;
	logic [31:0] next_pre;
	logic [6:0] next_units;
	logic next_fired;
	logic next_abort;
	logic tick;

	always_comb begin
		next_pre = pre;
		next_units = units;
		next_fired = fired;
		next_abort = 1'b0;
		tick = (pre == 32'(WDOG_UNIT - 1));
		if (!bcc_busy || wdog[bcs_pkg::WDOG_DIS]) begin
			next_pre = 32'h00000000;
			next_units = 7'h00;
			next_fired = 1'b0;
		end else if (!fired) begin
			next_pre = tick ? 32'h00000000 : pre + 32'h00000001;
			if (tick) begin
				next_units = units + 7'h01;
			end
			// A zero timeout aborts at the first unit; software avoids it
			if (tick && (units + 7'h01 >= wdog[7:1])) begin
				next_abort = 1'b1;
				next_fired = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre <= 32'h00000000;
			units <= 7'h00;
			fired <= 1'b0;
			bcc_abort <= 1'b0;
		end else begin
			pre <= next_pre;
			units <= next_units;
			fired <= next_fired;
			bcc_abort <= next_abort;
		end
	end

	// ====================================================================
	// Derived outputs, all registered
	bcs_pkg::bcs_src_t next_src;
	logic next_fwd0;
	logic next_fwd1;
	logic remote_hit;

	always_comb begin
		next_src = bcs_pkg::BCS_SRC_NONE;
		if (selftest[bcs_pkg::SELFTEST_EN]) begin
			unique case (selftest[2:1])
				2'b00: next_src = bcs_pkg::BCS_SRC_PIXEL;
				2'b01: next_src = bcs_pkg::BCS_SRC_OSC33;
				2'b10, 2'b11: next_src = bcs_pkg::BCS_SRC_OSC100;
			endcase
		end else if (!tmds_clk_present && osc_use) begin
			unique case (selftest[2:1])
				2'b00, 2'b01: next_src = bcs_pkg::BCS_SRC_OSC50;
				2'b10: next_src = bcs_pkg::BCS_SRC_OSC100;
				2'b11: next_src = bcs_pkg::BCS_SRC_OSC25;
			endcase
		end
		remote_hit = (acc_id == remote_deser_id) || (acc_id == remote_target_id);
		next_fwd0 = acc_valid && (pass0 ? (acc_id != own_id) : remote_hit);
		next_fwd1 = acc_valid && (pass1 ? (acc_id != own_id) : remote_hit);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_src <= bcs_pkg::BCS_SRC_NONE;
			self_test_en <= 1'b0;
			signalling_level_ctrl <= bcs_pkg::RST_LEVEL[0];
			fwd_port0 <= 1'b0;
			fwd_port1 <= 1'b0;
			sda_hold_steps <= bcs_pkg::RST_BUSSET[6:4];
			glitch_steps <= bcs_pkg::RST_BUSSET[3:0];
			scl_high_periods <= {1'b0, bcs_pkg::RST_SCLHIGH} + bcs_pkg::SCL_EXTRA;
		end else begin
			clk_src <= next_src;
			self_test_en <= selftest[bcs_pkg::SELFTEST_EN];
			signalling_level_ctrl <= level;
			fwd_port0 <= next_fwd0;
			fwd_port1 <= next_fwd1;
			sda_hold_steps <= busset[6:4];
			glitch_steps <= busset[3:0];
			scl_high_periods <= {1'b0, sclhigh} + bcs_pkg::SCL_EXTRA;
		end
	end

	// ====================================================================
	// Checks
	a_strap_done: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(latched) |-> strap_reg[bcs_pkg::STRAP_B_DONE] && strap_reg[bcs_pkg::STRAP_A_DONE])
		else $error("strap done bits not set at latch");
	a_strap_stable: assert property (@(posedge pclk) disable iff (!presetn)
		latched |=> $stable(strap_reg))
		else $error("strap status changed after latch");
	a_strap_a_range: assert property (@(posedge pclk) disable iff (!presetn)
		!strap_reg[2])
		else $error("strap A decode outside four modes");
	a_level_set: assert property (@(posedge pclk) disable iff (!presetn)
		wr && hit(paddr, bcs_pkg::IDX_LEVEL) && wd == bcs_pkg::LEVEL_SET |=> ##1 signalling_level_ctrl)
		else $error("level not set by magic write");
	a_level_clr: assert property (@(posedge pclk) disable iff (!presetn)
		wr && hit(paddr, bcs_pkg::IDX_LEVEL) && wd == bcs_pkg::LEVEL_CLR && !digital_reset
		|=> ##1 !signalling_level_ctrl)
		else $error("level not cleared by magic write");
	a_level_dreset: assert property (@(posedge pclk) disable iff (!presetn)
		digital_reset |=> level ##1 signalling_level_ctrl)
		else $error("digital reset did not force 3.3V");
	a_wdog_off: assert property (@(posedge pclk) disable iff (!presetn)
		wdog[bcs_pkg::WDOG_DIS] |=> !bcc_abort)
		else $error("watchdog fired while disabled");
	a_wdog_cause: assert property (@(posedge pclk) disable iff (!presetn)
		bcc_abort |-> $past(bcc_busy) && $past(units) + 7'h01 >= $past(wdog[7:1]))
		else $error("abort without expired timeout");
	a_scl_high: assert property (@(posedge pclk) disable iff (!presetn)
		scl_high_periods == {1'b0, $past(sclhigh)} + bcs_pkg::SCL_EXTRA)
		else $error("SCL high periods not count plus five");
	a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
		access && !pready |=> pready ##1 !pready)
		else $error("pready not a single cycle answer");
	a_fwd_own: assert property (@(posedge pclk) disable iff (!presetn)
		acc_valid && acc_id == own_id && !remote_hit |=> !fwd_port0 && !fwd_port1)
		else $error("own address forwarded");
	a_osc_map: assert property (@(posedge pclk) disable iff (!presetn)
		!selftest[0] && !tmds_clk_present && osc_use && selftest[2:1] == 2'b11
		|=> clk_src == bcs_pkg::BCS_SRC_OSC25)
		else $error("oscillator select 11 not 25 MHz");
endmodule : bcs_regs

/* testbench/bcs_host.sv */
// Host model: APB master issuing one register transfer per call
module bcs_host (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end
	// ====
	// Transfer
	// Request held until pready is seen high; only the bench watchdog ends a lost answer
	task xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx[5:0], 2'b00};
		pwdata <= {24'h00_0000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : bcs_host

/* testbench/test_bridge_config_status_regs.sv */
// Testbench for the bridge configuration and status register bank
module test_bridge_config_status_regs;
	timeunit 1ns;
	timeprecision 100ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [2:0] strap_pin_a, strap_pin_b, sda_hold_steps;
	logic strap_scl, digital_reset, tmds_clk_present, osc_use, bcc_busy;
	logic second_port_select, acc_valid, signalling_level_ctrl, self_test_en;
	logic bcc_abort, fwd_port0, fwd_port1;
	logic [6:0] acc_id;
	logic [3:0] glitch_steps;
	logic [8:0] scl_high_periods;
	bcs_pkg::bcs_src_t clk_src;
	int errors, check_count;
	logic [31:0] d;
	logic e;
	bcs_pkg::bcs_src_t src_exp [8] = '{bcs_pkg::BCS_SRC_OSC50, bcs_pkg::BCS_SRC_PIXEL,
		bcs_pkg::BCS_SRC_OSC50, bcs_pkg::BCS_SRC_OSC33, bcs_pkg::BCS_SRC_OSC100,
		bcs_pkg::BCS_SRC_OSC100, bcs_pkg::BCS_SRC_OSC25, bcs_pkg::BCS_SRC_OSC100};
	bcs_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	// Short counts keep the run brief
	bcs_regs #(.WDOG_UNIT(8), .SETTLE(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .strap_pin_a(strap_pin_a),
		.strap_pin_b(strap_pin_b), .strap_scl(strap_scl), .digital_reset(digital_reset),
		.tmds_clk_present(tmds_clk_present), .osc_use(osc_use), .bcc_busy(bcc_busy),
		.second_port_select(second_port_select), .acc_valid(acc_valid), .acc_id(acc_id),
		.own_id(7'h10), .remote_deser_id(7'h20), .remote_target_id(7'h30),
		.signalling_level_ctrl(signalling_level_ctrl), .clk_src(clk_src),
		.self_test_en(self_test_en), .bcc_abort(bcc_abort), .fwd_port0(fwd_port0),
		.fwd_port1(fwd_port1), .sda_hold_steps(sda_hold_steps), .glitch_steps(glitch_steps),
		.scl_high_periods(scl_high_periods));
	initial pclk = 1'b0;
	always #12.5 pclk = ~pclk;
	// ====
	// Helpers
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task rd(input logic [7:0] idx, input logic [7:0] exp);
		host.xfer(1'b0, idx, 8'h00, d, e);
		chk(d, {24'h00_0000, exp});
	endtask : rd
	task wr(input logic [7:0] idx, input logic [7:0] wd);
		host.xfer(1'b1, idx, wd, d, e);
		chk({31'h0, e}, 32'h0);
	endtask : wr
	task give_verdict;
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : give_verdict
	// ====
	// Scenarios
	task t_reset_vals;
		rd(bcs_pkg::IDX_SELFTEST, bcs_pkg::RST_SELFTEST);
		rd(bcs_pkg::IDX_WDOG, bcs_pkg::RST_WDOG);
		rd(bcs_pkg::IDX_BUSSET, bcs_pkg::RST_BUSSET);
		rd(bcs_pkg::IDX_SCLHIGH, bcs_pkg::RST_SCLHIGH);
		chk({23'h0, scl_high_periods}, 32'h84);
		chk({29'h0, sda_hold_steps}, 32'h1);
		chk({28'h0, glitch_steps}, 32'hE);
		host.xfer(1'b0, 8'h10, 8'h00, d, e);
		chk({d[30:0], e}, 32'h1);
	endtask : t_reset_vals
	task t_strap;
		d = 32'h0;
		for (int i = 0; i < 10 && d[7] !== 1'b1; i++) host.xfer(1'b0, bcs_pkg::IDX_STRAP, 8'h00, d, e);
		rd(bcs_pkg::IDX_STRAP, 8'hDB);
		strap_pin_b <= 3'h2;
		wr(bcs_pkg::IDX_STRAP, 8'h00);
		rd(bcs_pkg::IDX_STRAP, 8'hDB);
		rd(bcs_pkg::IDX_LEVEL, 8'h00);
		chk({31'h0, signalling_level_ctrl}, 32'h0);
	endtask : t_strap
	task t_level;
		digital_reset <= 1'b1;
		@(posedge pclk);
		digital_reset <= 1'b0;
		rd(bcs_pkg::IDX_LEVEL, 8'h01);
		wr(bcs_pkg::IDX_LEVEL, bcs_pkg::LEVEL_CLR);
		rd(bcs_pkg::IDX_LEVEL, 8'h00);
		wr(bcs_pkg::IDX_LEVEL, 8'h5A);
		rd(bcs_pkg::IDX_LEVEL, 8'h00);
		chk({31'h0, signalling_level_ctrl}, 32'h0);
		wr(bcs_pkg::IDX_LEVEL, bcs_pkg::LEVEL_SET);
		rd(bcs_pkg::IDX_LEVEL, 8'h01);
		chk({31'h0, signalling_level_ctrl}, 32'h1);
	endtask : t_level
	task t_clk;
		for (int i = 0; i < 8; i++) begin
			wr(bcs_pkg::IDX_SELFTEST, 8'(i));
			repeat (2) @(posedge pclk);
			chk({29'h0, clk_src}, {29'h0, src_exp[i]});
			chk({31'h0, self_test_en}, 32'(i % 2));
		end
		wr(bcs_pkg::IDX_SELFTEST, 8'hFC);
		rd(bcs_pkg::IDX_SELFTEST, 8'h04);
		tmds_clk_present <= 1'b1;
		repeat (3) @(posedge pclk);
		chk({29'h0, clk_src}, {29'h0, bcs_pkg::BCS_SRC_NONE});
		tmds_clk_present <= 1'b0;
		osc_use <= 1'b0;
		repeat (3) @(posedge pclk);
		chk({29'h0, clk_src}, {29'h0, bcs_pkg::BCS_SRC_NONE});
		osc_use <= 1'b1;
		repeat (3) @(posedge pclk);
		chk({29'h0, clk_src}, {29'h0, bcs_pkg::BCS_SRC_OSC100});
	endtask : t_clk
	task t_wdog;
		int n;
		logic seen;
		n = 0;
		seen = 1'b0;
		wr(bcs_pkg::IDX_WDOG, 8'h04);
		bcc_busy <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (bcc_abort !== 1'b1 && n < 40);
		chk({31'h0, (n >= 16 && n <= 19)}, 32'h1);
		bcc_busy <= 1'b0;
		wr(bcs_pkg::IDX_WDOG, 8'h05);
		bcc_busy <= 1'b1;
		repeat (40) begin
			@(posedge pclk);
			seen = seen | (bcc_abort !== 1'b0);
		end
		chk({31'h0, seen}, 32'h0);
		bcc_busy <= 1'b0;
	endtask : t_wdog
	task fwd(input logic [6:0] id, input logic [1:0] exp);
		logic [1:0] s;
		s = 2'b00;
		acc_id <= id;
		acc_valid <= 1'b1;
		@(posedge pclk);
		acc_valid <= 1'b0;
		repeat (3) begin
			@(posedge pclk);
			s = s | {fwd_port0, fwd_port1};
		end
		chk({30'h0, s}, {30'h0, exp});
	endtask : fwd
	task t_fwd;
		fwd(7'h20, 2'b11);
		fwd(7'h30, 2'b11);
		fwd(7'h44, 2'b00);
		wr(bcs_pkg::IDX_BUSSET, 8'h9E);
		fwd(7'h44, 2'b10);
		fwd(7'h10, 2'b00);
		second_port_select <= 1'b1;
		wr(bcs_pkg::IDX_BUSSET, 8'h9E);
		second_port_select <= 1'b0;
		wr(bcs_pkg::IDX_BUSSET, 8'h1E);
		fwd(7'h44, 2'b01);
		second_port_select <= 1'b1;
		rd(bcs_pkg::IDX_BUSSET, 8'h9E);
		second_port_select <= 1'b0;
	endtask : t_fwd
	task t_fields;
		wr(bcs_pkg::IDX_BUSSET, 8'h35);
		wr(bcs_pkg::IDX_SCLHIGH, 8'hFF);
		repeat (2) @(posedge pclk);
		chk({29'h0, sda_hold_steps}, 32'h3);
		chk({28'h0, glitch_steps}, 32'h5);
		chk({23'h0, scl_high_periods}, 32'h104);
	endtask : t_fields
	// ====
	// Main sequence and watchdog
	initial begin
		errors = 0;
		check_count = 0;
		presetn = 1'b0;
		strap_pin_a = 3'h7;
		strap_pin_b = 3'h5;
		strap_scl = 1'b1;
		digital_reset = 1'b0;
		tmds_clk_present = 1'b0;
		osc_use = 1'b1;
		bcc_busy = 1'b0;
		second_port_select = 1'b0;
		acc_valid = 1'b0;
		acc_id = 7'h00;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset_vals();
		t_strap();
		t_level();
		t_clk();
		t_wdog();
		t_fwd();
		t_fields();
		give_verdict();
	end
	// A healthy run ends well within this span
	initial begin
		#500000;
		errors++;
		give_verdict();
	end
endmodule : test_bridge_config_status_regs
